// ---- include/wdg_consts.svh ----
// Purpose: constants for the windowless watchdog timer
// Assumes: oscillator clock is the design clock REF_CLK at 125 MHz
// Notes: reset pulse count derived from a time in ns; prescale and wake counts given in cycles
`ifndef WDG_CONSTS_SVH
`define WDG_CONSTS_SVH
`define WDG_PRESCALE_CYCLES   14'h3FFF
`define WDG_CTRL_RESET        8'h7F
`define WDG_ACT_BIT           7
`define WDG_TOP_BIT           6
`define WDG_CLK_MHZ           125
`define WDG_RST_PULSE_NS      30000
`define WDG_RST_PULSE_CYC     ((`WDG_RST_PULSE_NS * `WDG_CLK_MHZ + 999) / 1000)
`define WDG_WAKE_SHORT        13'h0100
`define WDG_WAKE_LONG         13'h1000
`endif

// ---- include/wdg_pkg.sv ----
// Purpose: types for the windowless watchdog timer
// Assumes: nothing
// Notes: none
package wdg_pkg;
	typedef enum logic [1:0] {
		RUN      = 2'b00,
		HALT_ONE = 2'b01,
		STOPPED  = 2'b11,
		WAKE     = 2'b10
	} run_state_t;
	typedef struct packed {
		logic       act;
		logic [6:0] count;
	} ctrl_t;
	typedef struct packed {
		logic halt_req;
		logic ext_irq;
		logic osc_irq;
	} power_ev_t;
endpackage

// ---- hw/wdg_tick.sv ----
// Purpose: free-running prescaler giving one tick per period
// Assumes: clock enable freezes the count
// Notes: never cleared by counter writes
`timescale 1ns/1ps
`include "wdg_consts.svh"
module wdg_tick (
	// Clock, reset, enable
	input  wire logic REF_CLK,
	input  wire logic SRST,
	input  wire logic CE,
	// Output
	output logic      TICK
);
	logic [13:0] presc;

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			presc <= 14'h0000;
		end else if (CE) begin
			presc <= (presc == `WDG_PRESCALE_CYCLES) ? 14'h0000 : presc + 14'h0001;
		end
	end

	assign TICK = CE && (presc == `WDG_PRESCALE_CYCLES);
endmodule

// ---- hw/windowless_watchdog_timer.sv ----
// Purpose: seven-bit watchdog down-counter with reset pulse generation
// Assumes: control inputs come from logic on REF_CLK
// Notes: reset output is active low
`timescale 1ns/1ps
`include "wdg_consts.svh"
module windowless_watchdog_timer (
	// Clock, reset, enable
	input  wire logic                  REF_CLK,
	input  wire logic                  SRST,
	input  wire logic                  CE,
	// Control register write and read ports
	input  wire logic                  CTRL_WR,
	input  wire logic [7:0]            CTRL_WDATA,
	output logic [7:0]                 CTRL_RDATA,
	// Options and mode inputs
	input  wire logic                  HW_WDG_OPTION,
	input  wire logic                  HALT_RESET_OPTION,
	input  wire logic                  RTC_IRQ_ENABLE,
	input  wire logic                  LONG_WAKE_DELAY,
	input  wire wdg_pkg::power_ev_t    POWER_EV,
	// Outputs
	output logic                       WDG_RESET_N,
	output logic                       HALTED
);
	wdg_pkg::ctrl_t     ctrl;
	wdg_pkg::run_state_t state;
	logic               tick;
	logic [15:0]        pulse_cnt;
	logic [12:0]        wake_cnt;
	logic               active;
	logic               halt_enter;
	logic               fire;
	logic               roll;
	logic               counting;

	wdg_tick u_tick (
		.REF_CLK (REF_CLK),
		.SRST    (SRST),
		.CE      (CE),
		.TICK    (tick)
	);

	assign active     = HW_WDG_OPTION | ctrl.act;
	assign halt_enter = CE && POWER_EV.halt_req && (state == wdg_pkg::RUN);
	// SLOW and WAIT have no input here: counting ignores them
	assign counting   = (state == wdg_pkg::RUN) || (state == wdg_pkg::HALT_ONE);
	assign roll       = tick && counting && (ctrl.count == 7'h40);
	assign fire = CE && (
		(roll && active && (state == wdg_pkg::RUN)) ||
		// A write that clears the top bit while the watchdog is (or becomes) active resets
		(CTRL_WR && (CTRL_WDATA[`WDG_ACT_BIT] || active) && !CTRL_WDATA[`WDG_TOP_BIT]) ||
		(halt_enter && active && !RTC_IRQ_ENABLE && HALT_RESET_OPTION));

	// Control register
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			ctrl <= `WDG_CTRL_RESET;
		end else if (CE) begin
			if (CTRL_WR) begin
				ctrl.count <= CTRL_WDATA[6:0];
				ctrl.act   <= ctrl.act | CTRL_WDATA[`WDG_ACT_BIT];
			end else if (tick && counting) begin
				ctrl.count <= ctrl.count - 7'h01;
			end
		end
	end

	// Low-power sequencing
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			state    <= wdg_pkg::RUN;
			wake_cnt <= 13'h0000;
		end else if (CE) begin
			case (state)
				wdg_pkg::RUN: begin
					if (halt_enter && !(HALT_RESET_OPTION && !RTC_IRQ_ENABLE && active)) begin
						state <= RTC_IRQ_ENABLE ? wdg_pkg::STOPPED : wdg_pkg::HALT_ONE;
					end
				end
				wdg_pkg::HALT_ONE: begin
					if (POWER_EV.ext_irq) begin
						state    <= wdg_pkg::WAKE;
						wake_cnt <= LONG_WAKE_DELAY ? `WDG_WAKE_LONG : `WDG_WAKE_SHORT;
					end else if (tick) begin
						state <= wdg_pkg::STOPPED;
					end
				end
				wdg_pkg::STOPPED: begin
					if (RTC_IRQ_ENABLE && (POWER_EV.ext_irq || POWER_EV.osc_irq)) begin
						state <= wdg_pkg::RUN;
					end else if (!RTC_IRQ_ENABLE && POWER_EV.ext_irq) begin
						state    <= wdg_pkg::WAKE;
						wake_cnt <= LONG_WAKE_DELAY ? `WDG_WAKE_LONG : `WDG_WAKE_SHORT;
					end
				end
				wdg_pkg::WAKE: begin
					if (wake_cnt <= 13'h0001) begin
						state <= wdg_pkg::RUN;
					end
					wake_cnt <= wake_cnt - 13'h0001;
				end
				default: state <= wdg_pkg::RUN;
			endcase
		end
	end

	// Reset pulse; restart delay after reset is taken by the system reset itself
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			pulse_cnt <= 16'h0000;
		end else if (CE) begin
			if (fire) begin
				pulse_cnt <= 16'(`WDG_RST_PULSE_CYC);
			end else if (pulse_cnt != 16'h0000) begin
				pulse_cnt <= pulse_cnt - 16'h0001;
			end
		end
	end

	assign WDG_RESET_N = (pulse_cnt == 16'h0000);
	assign CTRL_RDATA  = ctrl;
	assign HALTED      = (state != wdg_pkg::RUN);
endmodule

// ---- test/wdg_chk.sv ----
// Purpose: port checker. Assumes: one clock. Notes: bound to the top module
`timescale 1ns/1ps
`include "wdg_consts.svh"
module wdg_chk (
	// Watched ports
	input wire logic REF_CLK, SRST, CE, CTRL_WR, HW_WDG_OPTION, HALT_RESET_OPTION,
	input wire logic RTC_IRQ_ENABLE, LONG_WAKE_DELAY, WDG_RESET_N, HALTED,
	input wire logic [7:0] CTRL_WDATA, CTRL_RDATA,
	input wire wdg_pkg::power_ev_t POWER_EV
);
	localparam int PULSE = `WDG_RST_PULSE_CYC;
	int low;
	wire act = CTRL_RDATA[7] || HW_WDG_OPTION;
	wire hreq = CE && !HALTED && POWER_EV.halt_req;
	always_ff @(posedge REF_CLK) low <= (SRST || WDG_RESET_N) ? 0 : low + int'(CE);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SRST);
	write_load_a: assert property (CE && CTRL_WR
		|=> CTRL_RDATA[6:0] == $past(CTRL_WDATA[6:0])) else $error("write not loaded");
	act_sticky_a: assert property (CTRL_RDATA[7] |=> CTRL_RDATA[7]) else $error("act lost");
	soft_rst_a: assert property (CE && CTRL_WR && CTRL_WDATA[7:6] == 2'b10
		|=> !WDG_RESET_N) else $error("no soft reset");
	roll_rst_a: assert property ($fell(CTRL_RDATA[6]) && act && !$past(CTRL_WR)
		&& !$past(HALTED) |-> ##[0:1] !WDG_RESET_N) else $error("no roll reset");
	pulse_len_a: assert property ($rose(WDG_RESET_N) |-> low >= PULSE)
		else $error("reset pulse short");
	halt_rst_a: assert property (hreq && !RTC_IRQ_ENABLE && HALT_RESET_OPTION && act
		|=> !WDG_RESET_N) else $error("no halt reset");
	halt_quiet_a: assert property (hreq && !RTC_IRQ_ENABLE && !HALT_RESET_OPTION
		&& !CTRL_WR && WDG_RESET_N |=> HALTED && WDG_RESET_N) else $error("halt wrong");
	active_halt_a: assert property (hreq && RTC_IRQ_ENABLE |=> HALTED)
		else $error("no active halt");
endmodule
bind windowless_watchdog_timer wdg_chk chk (.REF_CLK(REF_CLK), .SRST(SRST), .CE(CE),
	.CTRL_WR(CTRL_WR), .HW_WDG_OPTION(HW_WDG_OPTION), .HALT_RESET_OPTION(HALT_RESET_OPTION),
	.RTC_IRQ_ENABLE(RTC_IRQ_ENABLE), .LONG_WAKE_DELAY(LONG_WAKE_DELAY),
	.WDG_RESET_N(WDG_RESET_N), .HALTED(HALTED), .CTRL_WDATA(CTRL_WDATA),
	.CTRL_RDATA(CTRL_RDATA), .POWER_EV(POWER_EV));

// ---- test/test_windowless_watchdog_timer.sv ----
// Purpose: watchdog bench. Assumes: CE high. Notes: model count kept in m
`timescale 1ns/1ps
module test_windowless_watchdog_timer;
	logic clk = 0, srst = 1, wr = 0, hw = 0, hro = 0, rtc = 0, rst_n, halted;
	logic [7:0] wd = 8'h00, rd;
	logic [2:0] ev = 3'h0;
	int err_total = 0, cmp_count = 0, cyc = 0, low = 0, n, m;
	always #4 clk = ~clk;
	always @(posedge clk) begin
		low += !rst_n;
		if (++cyc == 95000) begin
			err_total++;
			complete_run();
		end
	end
	windowless_watchdog_timer DUT (.REF_CLK(clk), .SRST(srst), .CE(1'b1), .CTRL_WR(wr),
		.CTRL_WDATA(wd), .CTRL_RDATA(rd), .HW_WDG_OPTION(hw), .HALT_RESET_OPTION(hro),
		.RTC_IRQ_ENABLE(rtc), .LONG_WAKE_DELAY(1'b0), .POWER_EV(ev), .WDG_RESET_N(rst_n),
		.HALTED(halted));
	task automatic chk(input logic [15:0] seen, exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s exp %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic step(input logic [7:0] d, input logic [2:0] e, input logic w);
		@(posedge clk);
		#1 wr = w;
		wd = d;
		ev = e;
		@(posedge clk);
		#1 wr = 0;
		ev = 0;
	endtask
	task automatic wait_chg();
		logic [7:0] old;
		old = rd;
		n = 0;
		while (rd === old && n < 20000) begin
			@(posedge clk);
			#1 n++;
		end
	endtask
	task automatic complete_run();
		if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		n = $urandom(32'hF5DE185C);
		repeat (6) @(posedge clk);
		#1 srst = 0;
		chk(rd, 8'h7F, "reset");
		step(8'h40, 0, 1);
		wait_chg();
		chk(n <= 16384, 1, "phase");
		m = 8'h3F;
		chk(rd, m, "count");
		wait_chg();
		chk(n, 16384, "period");
		chk(low, 0, "gated");
		step(8'hC0, 0, 1);
		wait_chg();
		chk(rd, 8'hBF, "roll");
		repeat (3800) @(posedge clk);
		chk(low, 3750, "width");
		low = 0;
		m = 8'h80 + $urandom % 64;
		step(m, 0, 1);
		chk(rd, m, "load");
		chk(rst_n, 0, "soft");
		step(8'h7F, 0, 1);
		chk(rd, 8'hFF, "sticky");
		repeat (3800) @(posedge clk);
		chk(low, 3750, "rewidth");
		#1 rtc = 1;
		step(0, 3'b100, 0);
		chk(halted, 1, "ahalt");
		m = rd;
		repeat (16400) @(posedge clk);
		chk(rd, m, "frozen");
		step(0, 3'b001, 0);
		chk(halted, 0, "awake");
		rtc = 0;
		step(0, 3'b100, 0);
		chk(rst_n, 1, "quiet");
		step(0, 3'b010, 0);
		repeat (250) @(posedge clk);
		chk(halted, 1, "delay");
		repeat (10) @(posedge clk);
		chk(halted, 0, "resume");
		#1 hro = 1;
		step(0, 3'b100, 0);
		chk(rst_n, 0, "hreset");
		srst = 1;
		hw = 1;
		repeat (2) @(posedge clk);
		#1 srst = 0;
		chk(rd, 8'h7F, "clear");
		step(8'h3F, 0, 1);
		chk(rst_n, 0, "hwopt");
		complete_run();
	end
endmodule
